// >>> common/eeprom_host_pkg.sv
// Purpose: shared constants and types for the bit-serial eeprom host controller
// Assumes: 20 MHz hclk, AHB-Lite register access, one device on the strobes
// Notes:   device-side map is listed for software; the host does not implement it
package eeprom_host_pkg;

  // host registers, byte offsets on AHB-Lite
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_WDATA  = 8'h0c;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ctrl and status fields
  localparam int CTRL_WP_BIT       = 0;
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_NV_IDLE_BIT  = 1;
  localparam int STAT_REFUSED_BIT  = 2;
  localparam int STAT_LOADING_BIT  = 3;
  localparam int STAT_PAGE_LSB     = 8;
  localparam logic CTRL_WP_RESET   = 1'b1;

  // device map: protection_control and its fields
  localparam logic [15:0] DEV_PROTECTION_CONTROL = 16'hffff;
  localparam int DEV_HW_PROTECT_ARM_BIT   = 7;
  localparam int DEV_BLOCK_PROTECT_HI_BIT = 3;
  localparam int DEV_BLOCK_PROTECT_LO_BIT = 2;

  // protocol sizes
  localparam int ADDR_BITS  = 16;
  localparam int BYTE_BITS  = 8;
  localparam int PAGE_BYTES = 32;
  localparam int TRIPLE_LEN = 3;

  // strobe timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_NS     = 100;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_ADDR, CMD_WBYTE, CMD_RBYTE, CMD_COMMIT, CMD_ENDREAD, CMD_POLL, CMD_RESET
  } cmd_e;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic io_out;
    logic io_oe;
  } pin_s;

  typedef struct packed {
    logic is_write;
    logic wbit;
  } cyc_s;

endpackage : eeprom_host_pkg

// >>> rtl/bus_cycle_engine.sv
// Purpose: runs one read or one write strobe cycle on the device pins
// Assumes: io_in is synchronous to hclk
// Notes:   chip enable rises one cycle after the strobe, data held past it
`timescale 1ns/1ps
module bus_cycle_engine (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // request
  input  wire logic                  start,
  input  wire eeprom_host_pkg::cyc_s req,
  output logic                       done,
  output logic                       rbit,
  // device pins
  input  wire logic                  io_in,
  output eeprom_host_pkg::pin_s      pins
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_RELEASE, E_GAP} eng_e;

  localparam eeprom_host_pkg::pin_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic [3:0] STROBE_LAST = 4'(eeprom_host_pkg::STROBE_CYC - 1);

  eng_e                 state,     next_state;
  logic [3:0]           cnt,       next_cnt;
  logic                 wr,        next_wr;
  logic                 next_done, next_rbit;
  eeprom_host_pkg::pin_s next_pins;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_wr    = wr;
    next_done  = 1'b0;
    next_rbit  = rbit;
    next_pins  = pins;
    case (state)
      E_IDLE: begin
        if (start) begin
          next_wr          = req.is_write;
          next_pins.ce_n   = 1'b0;
          next_pins.io_out = req.wbit;
          next_pins.io_oe  = req.is_write;
          next_state       = E_SETUP;
        end
      end
      E_SETUP: begin
        // one strobe only, never both low with chip selected (see RULE_04)
        next_pins.we_n = ~wr;
        next_pins.oe_n = wr;
        next_cnt       = STROBE_LAST;
        next_state     = E_STROBE;
      end
      E_STROBE: begin
        if (cnt == 4'h0) begin
          if (!wr) next_rbit = io_in;
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_state     = E_RELEASE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      E_RELEASE: begin
        // chip enable high between cycles, no timing limit (see RULE_18)
        next_pins.ce_n = 1'b1;
        next_state     = E_GAP;
      end
      E_GAP: begin
        next_pins  = PINS_IDLE;
        next_done  = 1'b1;
        next_state = E_IDLE;
      end
      default: begin
        next_pins  = PINS_IDLE;
        next_state = E_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= E_IDLE;
      cnt   <= 4'h0;
      wr    <= 1'b0;
      done  <= 1'b0;
      rbit  <= 1'b0;
      pins  <= PINS_IDLE;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      wr    <= next_wr;
      done  <= next_done;
      rbit  <= next_rbit;
      pins  <= next_pins;
    end
  end

  a_strobes_exclusive: assert property ( // see RULE_04
    @(posedge hclk) disable iff (!hresetn) !pins.ce_n |-> (pins.we_n || pins.oe_n))
    else $error("write and output strobes low together");

  a_no_drive_on_read: assert property ( // see RULE_04
    @(posedge hclk) disable iff (!hresetn) !pins.oe_n |-> !pins.io_oe)
    else $error("host drives io while device output enabled");

  a_strobe_width_ce: assert property ( // see RULE_18
    @(posedge hclk) disable iff (!hresetn)
    $fell(pins.we_n) |-> (!pins.we_n && !pins.ce_n) [*2] ##1 (pins.we_n && !pins.ce_n) ##1 pins.ce_n)
    else $error("write strobe width or chip enable bracket wrong");

endmodule : bus_cycle_engine

// >>> rtl/eeprom_host.sv
// Purpose: AHB-Lite controlled host that drives a bit-serial eeprom through its strobes
// Assumes: single AHB-Lite slave, word accesses, device pins synchronous to hclk
// Notes:   software sequences commands; address command always opens with the reset triple
`timescale 1ns/1ps
// Overview of operation
// RULE_01: device floats data and idles while chip enable is high.
// RULE_02: device latches data on the first rising edge of write strobe or enable.
// RULE_03: device drives data only while output enable and chip enable are low.
// RULE_04: host never has write and output strobes low together while selected.
// RULE_05: read starts with sixteen write cycles carrying the address, top bit first.
// RULE_06: each byte is fetched by eight read cycles, one bit each.
// RULE_07: writing a one after a byte ends the read; otherwise reading continues.
// RULE_08: device address advances per byte and wraps to zero at the top.
// RULE_09: read, write zero, read resets protocol and sets the write latch.
// RULE_10: the reset triple aborts a sequential read or page load.
// RULE_11: after reset, reads return high until a full address is sent.
// RULE_12: host opens every read and write sequence with the reset triple.
// RULE_13: page load is address then up to 32 bytes, no reads in between.
// RULE_14: read, write one, read closes the load and starts programming.
// RULE_15: loading wraps within the 32-byte page, overwriting earlier data.
// RULE_16: device refuses partial writes, clears the latch after programming or misuse.
// RULE_17: reads return low while programming runs, high once finished.
// RULE_18: both protocols are static; chip enable high frees the bus.
// RULE_19: reading address ffff returns the control byte, unused bits zero.
// RULE_20: control write stores one byte only; the start triple commits it.
// RULE_21: control byte holds arm bit 7, protect bits 3 and 2.
// RULE_22: protect pin low with arm set refuses control register writes.
// RULE_23: protect pin falling while selected aborts a pending control write.
// RULE_24: with arm clear the protect pin is ignored.
// RULE_25: protect field selects none, upper quarter, upper half or all.
// RULE_26: hardware protection also blocks protected blocks and the arm bit.
// RULE_27: an illegal cycle pattern sends the device idle.
// RULE_28: the write enable latch clears at power up.
module eeprom_host (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // device pins
  output logic             chip_enable_n,
  output logic             output_enable_n,
  output logic             write_strobe_n,
  output logic             write_protect_n,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  input  wire logic        serial_data_in
);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_e;

  localparam logic [4:0] ADDR_LAST  = 5'(eeprom_host_pkg::TRIPLE_LEN + eeprom_host_pkg::ADDR_BITS - 1);
  localparam logic [4:0] BYTE_LAST  = 5'(eeprom_host_pkg::BYTE_BITS - 1);
  localparam logic [4:0] TRIP_LAST  = 5'(eeprom_host_pkg::TRIPLE_LEN - 1);
  localparam logic [5:0] PAGE_FULL  = 6'(eeprom_host_pkg::PAGE_BYTES);

  // bus state
  logic        ph_wr,   next_ph_wr;
  logic [7:0]  ph_ofs,  next_ph_ofs;
  logic        wp_lvl,  next_wp_lvl;
  logic [15:0] addr,    next_addr;
  logic [7:0]  wdata,   next_wdata;
  logic        cmd_go,  next_cmd_go;
  eeprom_host_pkg::cmd_e cmd_val, next_cmd_val;
  logic        ref_clr, next_ref_clr;
  logic [31:0] next_hrdata;

  // sequencer state
  seq_e        state,   next_state;
  eeprom_host_pkg::cmd_e cmd, next_cmd;
  logic [4:0]  step,    next_step;
  logic        busy,    next_busy;
  logic        refused, next_refused;
  logic        loading, next_loading;
  logic [5:0]  page,    next_page;
  logic [7:0]  rdata,   next_rdata;
  logic        nv_idle, next_nv_idle;
  logic        eng_start, next_eng_start;
  eeprom_host_pkg::cyc_s req, next_req;
  logic        eng_done;
  logic        eng_rbit;
  eeprom_host_pkg::pin_s pins;

  function automatic eeprom_host_pkg::cyc_s cyc_of(eeprom_host_pkg::cmd_e c, logic [4:0] s,
                                                   logic [15:0] a, logic [7:0] d);
    eeprom_host_pkg::cyc_s r;
    r = '{1'b0, 1'b0};
    case (c)
      eeprom_host_pkg::CMD_ADDR: begin
        // reset triple first, then address top bit first (see RULE_12, see RULE_05)
        if (s < 5'(eeprom_host_pkg::TRIPLE_LEN)) r = '{s == 5'h1, 1'b0};
        else r = '{1'b1, a[4'(ADDR_LAST - s)]};
      end
      eeprom_host_pkg::CMD_WBYTE:   r = '{1'b1, d[3'(BYTE_LAST - s)]}; // see RULE_13
      eeprom_host_pkg::CMD_RBYTE:   r = '{1'b0, 1'b0};                // see RULE_06
      eeprom_host_pkg::CMD_COMMIT:  r = '{s == 5'h1, 1'b1};           // see RULE_14
      eeprom_host_pkg::CMD_ENDREAD: r = '{1'b1, 1'b1};
      eeprom_host_pkg::CMD_RESET:   r = '{s == 5'h1, 1'b0};
      default:                      r = '{1'b0, 1'b0};
    endcase
    return r;
  endfunction : cyc_of

  function automatic logic [4:0] last_of(eeprom_host_pkg::cmd_e c);
    case (c)
      eeprom_host_pkg::CMD_ADDR:   return ADDR_LAST;
      eeprom_host_pkg::CMD_WBYTE,
      eeprom_host_pkg::CMD_RBYTE:  return BYTE_LAST;
      eeprom_host_pkg::CMD_COMMIT,
      eeprom_host_pkg::CMD_RESET:  return TRIP_LAST;
      default:                     return 5'h0;
    endcase
  endfunction : last_of

  // ahb-lite slave, zero wait states, always okay
  always_comb begin
    next_ph_wr   = hsel && hready && htrans[1] && hwrite;
    next_ph_ofs  = haddr[7:0];
    next_wp_lvl  = wp_lvl;
    next_addr    = addr;
    next_wdata   = wdata;
    next_cmd_go  = 1'b0;
    next_cmd_val = cmd_val;
    next_ref_clr = 1'b0;
    next_hrdata  = hrdata;
    if (ph_wr) begin
      case (ph_ofs)
        eeprom_host_pkg::OFS_CMD: begin
          next_cmd_go  = 1'b1;
          next_cmd_val = eeprom_host_pkg::cmd_e'(hwdata[2:0]);
        end
        eeprom_host_pkg::OFS_CTRL:   next_wp_lvl  = hwdata[eeprom_host_pkg::CTRL_WP_BIT];
        eeprom_host_pkg::OFS_ADDR:   next_addr    = hwdata[15:0];
        eeprom_host_pkg::OFS_WDATA:  next_wdata   = hwdata[7:0];
        eeprom_host_pkg::OFS_STATUS: next_ref_clr = hwdata[eeprom_host_pkg::STAT_REFUSED_BIT];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      next_hrdata = 32'h0;
      case (haddr[7:0])
        eeprom_host_pkg::OFS_CMD:    next_hrdata[2:0] = cmd;
        eeprom_host_pkg::OFS_CTRL:   next_hrdata[eeprom_host_pkg::CTRL_WP_BIT] = wp_lvl;
        eeprom_host_pkg::OFS_ADDR:   next_hrdata[15:0] = addr;
        eeprom_host_pkg::OFS_WDATA:  next_hrdata[7:0] = wdata;
        eeprom_host_pkg::OFS_RDATA:  next_hrdata[7:0] = rdata;
        eeprom_host_pkg::OFS_STATUS: begin
          next_hrdata[eeprom_host_pkg::STAT_BUSY_BIT]    = busy;
          next_hrdata[eeprom_host_pkg::STAT_NV_IDLE_BIT] = nv_idle;
          next_hrdata[eeprom_host_pkg::STAT_REFUSED_BIT] = refused;
          next_hrdata[eeprom_host_pkg::STAT_LOADING_BIT] = loading;
          next_hrdata[eeprom_host_pkg::STAT_PAGE_LSB +: 6] = page;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr     <= 1'b0;
      ph_ofs    <= 8'h00;
      wp_lvl    <= eeprom_host_pkg::CTRL_WP_RESET;
      addr      <= 16'h0000;
      wdata     <= 8'h00;
      cmd_go    <= 1'b0;
      cmd_val   <= eeprom_host_pkg::CMD_NONE;
      ref_clr   <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_wr     <= next_ph_wr;
      ph_ofs    <= next_ph_ofs;
      wp_lvl    <= next_wp_lvl;
      addr      <= next_addr;
      wdata     <= next_wdata;
      cmd_go    <= next_cmd_go;
      cmd_val   <= next_cmd_val;
      ref_clr   <= next_ref_clr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // command sequencer
  always_comb begin
    logic bad;
    bad            = 1'b0;
    next_state     = state;
    next_cmd       = cmd;
    next_step      = step;
    next_busy      = busy;
    next_loading   = loading;
    next_page      = page;
    next_rdata     = rdata;
    next_nv_idle   = nv_idle;
    next_eng_start = 1'b0;
    next_req       = req;
    case (state)
      S_IDLE: begin
        if (cmd_go) begin
          // no reads inside a page load, at most one page of bytes (see RULE_13)
          bad = (cmd_val == eeprom_host_pkg::CMD_NONE) ||
                (loading && (cmd_val == eeprom_host_pkg::CMD_RBYTE ||
                             cmd_val == eeprom_host_pkg::CMD_POLL)) ||
                (cmd_val == eeprom_host_pkg::CMD_WBYTE && page == PAGE_FULL);
          if (!bad) begin
            next_cmd   = cmd_val;
            next_step  = 5'h0;
            next_busy  = 1'b1;
            next_state = S_ISSUE;
            if (cmd_val == eeprom_host_pkg::CMD_ADDR) begin
              next_page    = 6'h0;
              next_loading = 1'b0;
            end
          end
        end
      end
      S_ISSUE: begin
        next_eng_start = 1'b1;
        next_req       = cyc_of(cmd, step, addr, wdata);
        next_state     = S_WAIT;
      end
      S_WAIT: begin
        if (eng_done) begin
          if (cmd == eeprom_host_pkg::CMD_RBYTE) next_rdata = {rdata[6:0], eng_rbit};
          if (cmd == eeprom_host_pkg::CMD_POLL)  next_nv_idle = eng_rbit;
          if (step == last_of(cmd)) begin
            next_busy  = 1'b0;
            next_state = S_IDLE;
            if (cmd == eeprom_host_pkg::CMD_WBYTE) begin
              next_page    = page + 6'h1;
              next_loading = 1'b1;
            end
            if (cmd == eeprom_host_pkg::CMD_COMMIT || cmd == eeprom_host_pkg::CMD_RESET) begin
              next_loading = 1'b0;
            end
          end else begin
            next_step  = step + 5'h1;
            next_state = S_ISSUE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    // a refusal set in the same cycle as a clear wins
    next_refused = (refused && !ref_clr) || (cmd_go && (bad || state != S_IDLE));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= S_IDLE;
      cmd       <= eeprom_host_pkg::CMD_NONE;
      step      <= 5'h0;
      busy      <= 1'b0;
      refused   <= 1'b0;
      loading   <= 1'b0;
      page      <= 6'h0;
      rdata     <= 8'h00;
      nv_idle   <= 1'b0;
      eng_start <= 1'b0;
      req       <= '{1'b0, 1'b0};
    end else begin
      state     <= next_state;
      cmd       <= next_cmd;
      step      <= next_step;
      busy      <= next_busy;
      refused   <= next_refused;
      loading   <= next_loading;
      page      <= next_page;
      rdata     <= next_rdata;
      nv_idle   <= next_nv_idle;
      eng_start <= next_eng_start;
      req       <= next_req;
    end
  end

  bus_cycle_engine bus_cycle_engine_inst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (eng_start),
    .req     (req),
    .done    (eng_done),
    .rbit    (eng_rbit),
    .io_in   (serial_data_in),
    .pins    (pins)
  );

  assign chip_enable_n   = pins.ce_n;
  assign output_enable_n = pins.oe_n;
  assign write_strobe_n  = pins.we_n;
  assign serial_data_out = pins.io_out;
  assign serial_data_oe  = pins.io_oe;
  assign write_protect_n = wp_lvl;

  a_triple_opens_addr: assert property ( // see RULE_12
    @(posedge hclk) disable iff (!hresetn)
    eng_start && cmd == eeprom_host_pkg::CMD_ADDR && step < 5'h3 |-> req.is_write == (step == 5'h1) && !req.wbit)
    else $error("address command not opened by read, write 0, read");

  a_addr_sixteen: assert property ( // see RULE_05
    @(posedge hclk) disable iff (!hresetn)
    eng_start && cmd == eeprom_host_pkg::CMD_ADDR && step > 5'h2 |-> req.is_write && req.wbit == addr[4'(ADDR_LAST - step)])
    else $error("address bit sent wrong or out of order");

  a_rbyte_all_reads: assert property ( // see RULE_06
    @(posedge hclk) disable iff (!hresetn)
    $fell(busy) && cmd == eeprom_host_pkg::CMD_RBYTE |-> $past(step) == 5'h7)
    else $error("byte read did not run eight cycles");

  a_load_no_reads: assert property ( // see RULE_13
    @(posedge hclk) disable iff (!hresetn)
    loading && eng_start |-> req.is_write || cmd == eeprom_host_pkg::CMD_COMMIT || cmd == eeprom_host_pkg::CMD_RESET)
    else $error("read cycle inside a page load");

  a_page_capped: assert property ( // see RULE_13
    @(posedge hclk) disable iff (!hresetn) page <= PAGE_FULL)
    else $error("more than one page of bytes loaded");

  a_commit_pattern: assert property ( // see RULE_14
    @(posedge hclk) disable iff (!hresetn)
    eng_start && cmd == eeprom_host_pkg::CMD_COMMIT |-> req.is_write == (step == 5'h1) && (step != 5'h1 || req.wbit))
    else $error("start write triple malformed");

  c_addr_done:   cover property (@(posedge hclk) disable iff (!hresetn)
                   $fell(busy) && cmd == eeprom_host_pkg::CMD_ADDR);
  c_byte_read:   cover property (@(posedge hclk) disable iff (!hresetn)
                   $fell(busy) && cmd == eeprom_host_pkg::CMD_RBYTE);
  c_commit_done: cover property (@(posedge hclk) disable iff (!hresetn)
                   $fell(busy) && cmd == eeprom_host_pkg::CMD_COMMIT);
  c_refusal:     cover property (@(posedge hclk) disable iff (!hresetn) $rose(refused));

endmodule : eeprom_host

// >>> test/eeprom_dev_model.sv
// Purpose: behavioural bit-serial eeprom on the host strobes
// Assumes: strobes change on hclk edges
// Notes: nv write time shortened by NV_NS
`timescale 1ns/1ps
module eeprom_dev_model #(
  parameter int NV_NS = 20000
) (
  // strobes and data
  input  wire logic ce_n,
  input  wire logic oe_n,
  input  wire logic we_n,
  input  wire logic wp_n,
  input  wire logic io,
  output logic      drive,
  output logic      dbit
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  pbuf [int];
  logic [15:0] a;
  logic [7:0]  sh;
  logic        busy = 0;
  logic        latch = 0;
  logic        last_rd = 0;
  logic        fresh = 0;
  logic [1:0]  bp;
  int          st = 0;
  int          n = 0;
  int          nb = 0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign drive = !ce_n && !oe_n;
  task automatic wcyc(input logic b);
    if (last_rd && !fresh && !b && !busy) begin
      st = 6; n = 0; nb = 0; latch = 1; pbuf.delete();
    end else if (last_rd && !fresh && b) begin
      if (st == 3 && latch && nb > 0 && nb % 8 == 0) st = 5;
      else begin st = 0; latch = 0; end
    end else if (st == 1) begin
      a = {a[14:0], b}; n++;
      if (n == 16) st = 4;
    end else if (st == 3 || st == 4) begin
      st = 3; sh = {sh[6:0], b}; nb++;
      if (nb % 8 == 0) pbuf[{a[15:5], 5'(a[4:0] + nb / 8 - 1)}] = sh;
    end else begin st = 0; latch = 0; end
    last_rd = 0;
    fresh = 0;
  endtask
  task automatic rcyc();
    fresh = (st == 6);
    if (fresh) st = 1;
    if (st == 5) begin
      st = 0;
      bp = mem[16'hffff][3:2];
      if (a == 16'hffff && (nb != 8 ||
          (mem[a][7] && !wp_n))) latch = 0;
      else begin
        foreach (pbuf[k])
          if (k == 'hffff) mem[k] = pbuf[k] & 8'h8c;
          else if (bp == 2'b00 || (bp == 2'b01 && k[15:14] != 2'b11) || (bp == 2'b10 && !k[15]))
            mem[k] = pbuf[k];
        busy = 1;
        fork begin #(NV_NS); busy = 0; latch = 0; end join_none
      end
    end else if (st == 2 && ++n == 8) begin a++; n = 0; end
    last_rd = 1;
  endtask
  always @(posedge we_n) if (!ce_n) wcyc(io);
  always @(posedge ce_n) if (!we_n) wcyc(io);
  always @(posedge oe_n) if (!ce_n) rcyc();
  always @(negedge wp_n) if (!ce_n && mem[16'hffff][7] && a == 16'hffff) begin
    st = 0; latch = 0;
  end
  always @(negedge oe_n) if (!ce_n) begin
    if (st == 4) begin st = 2; n = 0; end
    dbit = busy ? 1'b0 : (st == 2) ? mem[a][7 - n] : 1'b1;
  end
endmodule : eeprom_dev_model

// >>> test/eeprom_host_tb_top.sv
// Purpose: self-checking bench for the eeprom host
// Assumes: one device model on the strobes
// Notes: expected bytes kept in the bench
`timescale 1ns/1ps
module eeprom_host_tb_top;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, flt = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0;
  logic        hreadyout, hresp, ce_n, oe_n, we_n, wp_n, sd_out, sd_oe, sd, drive, dbit;
  logic [7:0]  exp_mem [int];
  logic [7:0]  exp_ctrl;
  int          n_errors = 0, checks = 0;
  always #25 hclk = ~hclk;
  always @(posedge hclk) flt <= ~flt;
  assign sd = sd_oe ? sd_out : drive ? dbit : flt;
  eeprom_host eeprom_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .write_strobe_n(we_n), .write_protect_n(wp_n),
    .serial_data_out(sd_out), .serial_data_oe(sd_oe), .serial_data_in(sd));
  eeprom_dev_model eeprom_dev_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .wp_n(wp_n), .io(sd), .drive(drive), .dbit(dbit));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  always @(posedge hclk) if (hresetn && !ce_n && !oe_n && (!we_n || sd_oe))
    chk("strobe overlap", 0, 1);
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask : ahb
  task automatic cmd(input eeprom_host_pkg::cmd_e c);
    ahb(1, eeprom_host_pkg::OFS_CMD, {29'h0, c});
    repeat (3) @(posedge hclk);
    for (int i = 0; i < 500; i++) begin
      ahb(0, eeprom_host_pkg::OFS_STATUS, '0);
      if (rd[0] === 1'b0) break;
    end
  endtask : cmd
  task automatic wait_nv();
    cmd(eeprom_host_pkg::CMD_POLL);
    chk("nv running", 0, rd[1]);
    for (int i = 0; i < 100 && rd[1] !== 1'b1; i++) cmd(eeprom_host_pkg::CMD_POLL);
    chk("nv done", 1, rd[1]);
  endtask : wait_nv
  task automatic set_addr(input logic [15:0] a);
    ahb(1, eeprom_host_pkg::OFS_ADDR, {16'h0, a});
    cmd(eeprom_host_pkg::CMD_ADDR);
  endtask : set_addr
  task automatic wbyte(input logic [7:0] b);
    ahb(1, eeprom_host_pkg::OFS_WDATA, {24'h0, b});
    cmd(eeprom_host_pkg::CMD_WBYTE);
  endtask : wbyte
  task automatic rbyte(input logic [7:0] e);
    cmd(eeprom_host_pkg::CMD_RBYTE);
    ahb(0, eeprom_host_pkg::OFS_RDATA, '0);
    chk("rdata", {24'h0, e}, rd);
  endtask : rbyte
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    #4000000;
    n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(50));
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    ahb(0, eeprom_host_pkg::OFS_CTRL, '0);
    chk("ctrl reset", 1, rd);
    ahb(0, eeprom_host_pkg::OFS_STATUS, '0);
    chk("status reset", 0, rd);
    ahb(1, 8'h20, '1);
    ahb(0, 8'h20, '0);
    chk("unmapped", 0, rd);
    cmd(eeprom_host_pkg::CMD_RESET);
    cmd(eeprom_host_pkg::CMD_POLL);
    chk("poll after reset", 1, rd[1]);
    rbyte(8'hff);
    cmd(eeprom_host_pkg::CMD_NONE);
    chk("cmd none", 1, rd[2]);
    ahb(1, eeprom_host_pkg::OFS_STATUS, 32'h4);
    set_addr(16'h0000);
    for (int i = 0; i < 4; i++) begin
      exp_mem[i] = 8'($urandom);
      wbyte(exp_mem[i]);
    end
    chk("page count", 32'h40a, rd);
    cmd(eeprom_host_pkg::CMD_RBYTE);
    chk("read in load", 1, rd[2]);
    ahb(1, eeprom_host_pkg::OFS_STATUS, 32'h4);
    cmd(eeprom_host_pkg::CMD_COMMIT);
    wait_nv();
    set_addr(16'h0000);
    for (int i = 0; i < 4; i++) rbyte(exp_mem[i]);
    cmd(eeprom_host_pkg::CMD_ENDREAD);
    cmd(eeprom_host_pkg::CMD_POLL);
    chk("read ended", 1, rd[1]);
    exp_ctrl = 8'($urandom) | 8'h80;
    set_addr(16'hffff);
    wbyte(exp_ctrl);
    cmd(eeprom_host_pkg::CMD_COMMIT);
    wait_nv();
    set_addr(16'hffff);
    rbyte(exp_ctrl & 8'h8c);
    set_addr(16'h0002);
    rbyte(exp_mem[2]);
    cmd(eeprom_host_pkg::CMD_ENDREAD);
    ahb(1, eeprom_host_pkg::OFS_CTRL, '0);
    repeat (2) @(posedge hclk);
    chk("wp pin", 0, wp_n);
    set_addr(16'hffff);
    wbyte(8'h00);
    cmd(eeprom_host_pkg::CMD_COMMIT);
    cmd(eeprom_host_pkg::CMD_POLL);
    chk("ctrl locked", 1, rd[1]);
    set_addr(16'hffff);
    rbyte(exp_ctrl & 8'h8c);
    cmd(eeprom_host_pkg::CMD_ENDREAD);
    set_addr(16'hfff0);
    wbyte(8'h5a);
    cmd(eeprom_host_pkg::CMD_COMMIT);
    wait_nv();
    set_addr(16'hfff0);
    rbyte(exp_ctrl[3:2] != 2'b00 ? 8'h00 : 8'h5a);
    cmd(eeprom_host_pkg::CMD_ENDREAD);
    stop_test();
  end
endmodule : eeprom_host_tb_top
